// file: core/scr_map.svh
// constants and register map of the smart card serial channel
// Function
// [RULE_01] all bit timing comes from a base clock at 372 times the bit rate
// [RULE_02] receiver aligns to the start bit falling edge seen on base clock
// [RULE_03] each received bit is latched on the 186th base clock pulse
// [RULE_04] one character frame spans ten bit periods
// [RULE_05] bad received parity sets parity fault, error irq if rx irq enabled
// [RULE_06] host clears parity fault before next frame's parity sample point
// [RULE_07] a frame with parity error never sets the receive-full flag
// [RULE_08] good parity sets receive-full and raises rx irq if enabled
// [RULE_09] dma read of receive data clears the receive-full flag
// [RULE_10] after a good frame the data line stays released in error slot
// [RULE_11] error signal after a sent frame sets flag, error irq if enabled
// [RULE_12] host clears error signal flag before next parity sample point
// [RULE_13] transmit-done stays clear for a frame answered by an error signal
// [RULE_14] frame without error signal sets transmit-done, tx irq if enabled
// [RULE_15] dma write of transmit data clears the transmit-data-empty flag
// [RULE_16] before standby host sets idle pin level and stops tx and rx
// [RULE_17] clock stop finishes the current period then holds idle level
// [RULE_18] host zeroes mode registers after the clock stops, before standby
// [RULE_19] on wake host sets idle level to pin level, then restarts clock
// [RULE_20] clock restart from idle gives a full first pulse
// [RULE_21] clock pin is released after reset until configured
// [RULE_22] at power-on host sets idle level, modes, then clock enable
// [RULE_23] error signal while sending resends the same character
// [RULE_24] no separate transmit-end interrupt in this mode
// [RULE_25] receiver drives line low in guard bit after a bad parity
`ifndef SCR_MAP_SVH
`define SCR_MAP_SVH
// register offsets
`define SCR_ADDR_CTRL  3'h0
`define SCR_ADDR_MODE  3'h1
`define SCR_ADDR_CARD  3'h2
`define SCR_ADDR_STS   3'h3
`define SCR_ADDR_TXD   3'h4
`define SCR_ADDR_RXD   3'h5
`define SCR_ADDR_DIV   3'h6
// control fields
`define SCR_CTRL_TIE   7
`define SCR_CTRL_RIE   6
`define SCR_CTRL_TE    5
`define SCR_CTRL_RE    4
`define SCR_CTRL_IDLE  1
`define SCR_CTRL_CKEN  0
`define SCR_MODE_ODD   4
`define SCR_CARD_ON    0
// status fields
`define SCR_STS_TDE    7
`define SCR_STS_RXF    6
`define SCR_STS_ORUN   5
`define SCR_STS_PERR   4
`define SCR_STS_ERS    3
`define SCR_STS_TX_DONE_FLAG   2
// reset values
`define SCR_CTRL_RST   8'h00
`define SCR_MODE_RST   8'h00
`define SCR_CARD_RST   8'h00
`define SCR_DIV_RST    8'h01
// timing counts in base clock pulses and bit periods
`define SCR_BASE_PER   9'h174
`define SCR_SAMPLE_NUM 9'h0BA
`define SCR_PAR_BIT    4'h9
`define SCR_SLOT_BIT   4'hA
`define SCR_LAST_BIT   4'hB
`endif

// file: core/scr_pkg.sv
// types shared by the smart card serial channel
package scr_pkg;
	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_SEND = 3'b010,
		TX_SLOT = 3'b100
	} scr_tx_e;
	typedef enum logic [2:0] {
		RX_IDLE = 3'b001,
		RX_DATA = 3'b010,
		RX_SLOT = 3'b100
	} scr_rx_e;
endpackage : scr_pkg

// file: core/scr_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module scr_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst,
	// level in and out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_ff;

	// first stage feeds only the second
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meta_ff <= '1;
			q       <= '1;
		end else begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end
endmodule : scr_sync

// file: core/scr_clkgen.sv
// card clock generator giving the base clock tick
`timescale 1ns/1ps
module scr_clkgen (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// control
	input  wire logic       en,
	input  wire logic       idle,
	input  wire logic [7:0] half,
	// outputs
	output logic            base_tick,
	output logic            sck_ff
);
	logic       run_ff;
	logic       ph_ff;
	logic [7:0] cnt_ff;
	wire        half_end = (cnt_ff == half - 8'h01);

	// period is a high half then a low half, each half sys cycles
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			run_ff    <= 1'b0;
			ph_ff     <= 1'b0;
			cnt_ff    <= 8'h00;
			sck_ff    <= 1'b0;
			base_tick <= 1'b0;
		end else begin
			base_tick <= 1'b0;
			if (!run_ff) begin
				sck_ff <= idle;
				if (en) begin                       // RULE_20
					run_ff    <= 1'b1;
					ph_ff     <= 1'b0;
					cnt_ff    <= 8'h00;
					sck_ff    <= 1'b1;
					base_tick <= 1'b1;
				end
			end else if (half_end) begin
				cnt_ff <= 8'h00;
				if (!ph_ff) begin
					ph_ff  <= 1'b1;
					sck_ff <= 1'b0;
				end else begin
					ph_ff <= 1'b0;
					if (en) begin
						sck_ff    <= 1'b1;
						base_tick <= 1'b1;          // RULE_01
					end else begin
						run_ff <= 1'b0;             // RULE_17
						sck_ff <= idle;
					end
				end
			end else begin
				cnt_ff <= cnt_ff + 8'h01;
			end
		end
	end

	a_full_first: // RULE_20
		assert property (@(posedge clk_sys) disable iff (rst)
			base_tick |-> sck_ff && !ph_ff && cnt_ff == 8'h00)
		else $error("clock period did not start with a full high half");
	a_stop_idle: // RULE_17
		assert property (@(posedge clk_sys) disable iff (rst)
			run_ff && ph_ff && half_end && !en
			|=> !run_ff && sck_ff == $past(idle))
		else $error("clock did not stop at idle after a whole period");
endmodule : scr_clkgen

// file: core/scr_top.sv
// smart card serial channel: framing, retransmit, flags and registers
`timescale 1ns/1ps
`include "scr_map.svh"
module scr_top
	import scr_pkg::*;
(
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// register port
	input  wire logic [2:0] addr,
	input  wire logic [7:0] wr_data,
	input  wire logic       wr_stb,
	input  wire logic       rd_stb,
	input  wire logic       dma_access,
	output logic      [7:0] rd_data_ff,
	// interrupt requests
	output logic            error_irq_ff,
	output logic            rx_full_irq_ff,
	output logic            tx_empty_irq_ff,
	// card data line
	input  wire logic       io_in,
	output logic            io_out_ff,
	output logic            io_oe_n_ff,
	// card clock pin
	output logic            sck_out,
	output logic            sck_oe_n_ff
);
	// software registers
	logic [7:0] ctrl_ff;
	logic [7:0] mode_ff;
	logic [7:0] card_ff;
	logic [7:0] div_ff;
	logic [7:0] txd_ff;
	logic [7:0] rxd_ff;
	// status flags
	logic       tde_ff;
	logic       rxf_ff;
	logic       orun_ff;
	logic       perr_ff;
	logic       ers_ff;
	logic       tx_done_flag_ff;
	// transmitter
	scr_tx_e    tx_st_ff;
	logic [8:0] tx_cnt_ff;
	logic [3:0] tx_bit_ff;
	logic [9:0] tx_frame_ff;
	logic       tx_err_ff;
	// receiver
	scr_rx_e    rx_st_ff;
	logic [8:0] rx_cnt_ff;
	logic [3:0] rx_bit_ff;
	logic [9:0] rx_sh_ff;
	logic       rx_bad_ff;
	logic       rx_prev_ff;
	logic       line_s;
	logic       base_tick;

	// parity bit that makes data plus parity even, or odd when asked
	function automatic logic scr_par(input logic [7:0] d, input logic odd);
		scr_par = (^d) ^ odd;
	endfunction : scr_par

	wire card_on = card_ff[`SCR_CARD_ON];
	wire odd     = mode_ff[`SCR_MODE_ODD];
	wire rx_irq_enable     = ctrl_ff[`SCR_CTRL_RIE];
	wire tx_irq_enable     = ctrl_ff[`SCR_CTRL_TIE];

	// bus decode
	wire wr_ctrl = wr_stb && addr == `SCR_ADDR_CTRL;
	wire wr_mode = wr_stb && addr == `SCR_ADDR_MODE;
	wire wr_card = wr_stb && addr == `SCR_ADDR_CARD;
	wire wr_sts  = wr_stb && addr == `SCR_ADDR_STS;
	wire wr_txd  = wr_stb && addr == `SCR_ADDR_TXD;
	wire wr_div  = wr_stb && addr == `SCR_ADDR_DIV;
	wire rd_rxd  = rd_stb && addr == `SCR_ADDR_RXD;
	wire dma_txd = wr_txd && dma_access;
	wire dma_rxd = rd_rxd && dma_access;

	// base clock and card clock pin
	scr_clkgen u_clk (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.en        (ctrl_ff[`SCR_CTRL_CKEN]),
		.idle      (ctrl_ff[`SCR_CTRL_IDLE]),
		.half      (div_ff),
		.base_tick (base_tick),
		.sck_ff    (sck_out)
	);

	// data line comes from outside, so it is synchronised first
	scr_sync #(.W(1)) u_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.d       (io_in),
		.q       (line_s)
	);

	// transmitter events
	wire tx_start = tx_st_ff == TX_IDLE && ctrl_ff[`SCR_CTRL_TE]
		&& card_on && !tde_ff;
	wire tx_bit_end = base_tick && tx_cnt_ff == `SCR_BASE_PER - 9'h001;
	wire tx_err_seen = tx_st_ff == TX_SLOT && base_tick
		&& tx_bit_ff == `SCR_SLOT_BIT
		&& tx_cnt_ff == `SCR_SAMPLE_NUM - 9'h001 && !line_s;
	wire tx_end_evt = tx_st_ff == TX_SLOT && tx_bit_end
		&& tx_bit_ff == `SCR_LAST_BIT;
	wire tx_good_end = tx_end_evt && !tx_err_ff;

	// receiver events
	wire rx_smp = rx_st_ff == RX_DATA && base_tick
		&& rx_cnt_ff == `SCR_SAMPLE_NUM - 9'h001;
	wire rx_bit_end = base_tick && rx_cnt_ff == `SCR_BASE_PER - 9'h001;
	wire rx_par_chk = rx_smp && rx_bit_ff == `SCR_PAR_BIT;
	wire rx_ok = line_s == scr_par(rx_sh_ff[8:1], odd);
	wire rx_par_bad = rx_par_chk && !rx_ok;
	wire rx_par_ok = rx_par_chk && rx_ok;

	// control registers written by software
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrl_ff <= `SCR_CTRL_RST;
			mode_ff <= `SCR_MODE_RST;
			card_ff <= `SCR_CARD_RST;
			div_ff  <= `SCR_DIV_RST;
			txd_ff  <= 8'h00;
		end else begin
			if (wr_ctrl)
				ctrl_ff <= wr_data;
			if (wr_mode)
				mode_ff <= wr_data;
			if (wr_card)
				card_ff <= wr_data;
			if (wr_div)
				div_ff <= wr_data;
			if (wr_txd)
				txd_ff <= wr_data;
		end
	end

	// status flags: hardware set wins over a clear in the same cycle
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tde_ff  <= 1'b1;
			tx_done_flag_ff <= 1'b1;
			rxf_ff  <= 1'b0;
			orun_ff <= 1'b0;
			perr_ff <= 1'b0;
			ers_ff  <= 1'b0;
		end else begin
			tde_ff  <= tx_good_end | (tde_ff                       // RULE_15
				& ~(dma_txd | (wr_sts & ~wr_data[`SCR_STS_TDE])));
			tx_done_flag_ff <= tx_good_end                                 // RULE_14
				| (tx_done_flag_ff & ~(tx_start | dma_txd));               // RULE_13
			rxf_ff  <= rx_par_ok | (rxf_ff                         // RULE_08
				& ~(dma_rxd | (wr_sts & ~wr_data[`SCR_STS_RXF])));  // RULE_09
			orun_ff <= (rx_par_ok & rxf_ff)
				| (orun_ff & ~(wr_sts & ~wr_data[`SCR_STS_ORUN]));
			perr_ff <= rx_par_bad                                  // RULE_05
				| (perr_ff & ~(wr_sts & ~wr_data[`SCR_STS_PERR]));
			ers_ff  <= tx_err_seen                                 // RULE_11
				| (ers_ff & ~(wr_sts & ~wr_data[`SCR_STS_ERS]));
		end
	end

	// interrupt levels; there is no transmit-end request here
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			error_irq_ff    <= 1'b0;
			rx_full_irq_ff  <= 1'b0;
			tx_empty_irq_ff <= 1'b0;
		end else begin
			error_irq_ff    <= rx_irq_enable & (orun_ff | perr_ff | ers_ff); // RULE_05
			rx_full_irq_ff  <= rx_irq_enable & rxf_ff;                       // RULE_08
			tx_empty_irq_ff <= tx_irq_enable & tx_done_flag_ff;                      // RULE_24
		end
	end

	// transmit sequencer: ten bit frame, then guard and error slot
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_st_ff    <= TX_IDLE;
			tx_cnt_ff   <= 9'h000;
			tx_bit_ff   <= 4'h0;
			tx_frame_ff <= 10'h3FF;
			tx_err_ff   <= 1'b0;
		end else begin
			if (tx_st_ff != TX_IDLE && base_tick)
				tx_cnt_ff <= tx_bit_end ? 9'h000 : tx_cnt_ff + 9'h001;
			case (tx_st_ff)
				TX_IDLE: begin
					if (tx_start) begin
						tx_frame_ff <= {scr_par(txd_ff, odd), txd_ff, 1'b0};
						tx_st_ff    <= TX_SEND;
						tx_cnt_ff   <= 9'h000;
						tx_bit_ff   <= 4'h0;
					end
				end
				TX_SEND: begin
					if (tx_bit_end) begin
						tx_bit_ff <= tx_bit_ff + 4'h1;
						if (tx_bit_ff == `SCR_PAR_BIT) begin // RULE_04
							tx_st_ff  <= TX_SLOT;
							tx_err_ff <= 1'b0;
						end
					end
				end
				TX_SLOT: begin
					if (tx_err_seen)
						tx_err_ff <= 1'b1;                   // RULE_25
					if (tx_end_evt) begin
						tx_bit_ff <= 4'h0;
						tx_st_ff  <= tx_err_ff ? TX_SEND : TX_IDLE; // RULE_23
					end else if (tx_bit_end) begin
						tx_bit_ff <= tx_bit_ff + 4'h1;
					end
				end
				default: tx_st_ff <= TX_IDLE;
			endcase
		end
	end

	// receive sequencer aligned to the start edge seen on base ticks
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rx_st_ff   <= RX_IDLE;
			rx_cnt_ff  <= 9'h000;
			rx_bit_ff  <= 4'h0;
			rx_sh_ff   <= 10'h000;
			rx_bad_ff  <= 1'b0;
			rx_prev_ff <= 1'b1;
		end else begin
			if (base_tick)
				rx_prev_ff <= line_s;
			if (rx_st_ff != RX_IDLE && base_tick)
				rx_cnt_ff <= rx_bit_end ? 9'h000 : rx_cnt_ff + 9'h001;
			case (rx_st_ff)
				RX_IDLE: begin
					if (base_tick && rx_prev_ff && !line_s
						&& ctrl_ff[`SCR_CTRL_RE] && card_on) begin // RULE_02
						rx_st_ff  <= RX_DATA;
						rx_cnt_ff <= 9'h000;
						rx_bit_ff <= 4'h0;
						rx_bad_ff <= 1'b0;
					end
				end
				RX_DATA: begin
					if (rx_smp) begin
						rx_sh_ff[rx_bit_ff] <= line_s;       // RULE_03
						if (rx_bit_ff == 4'h0 && line_s)
							rx_st_ff <= RX_IDLE;             // false start
						if (rx_par_bad)
							rx_bad_ff <= 1'b1;
					end
					if (rx_bit_end) begin
						rx_bit_ff <= rx_bit_ff + 4'h1;
						if (rx_bit_ff == `SCR_PAR_BIT)
							rx_st_ff <= RX_SLOT;             // RULE_04
					end
				end
				RX_SLOT: begin
					if (rx_bit_end) begin
						rx_bit_ff <= rx_bit_ff + 4'h1;
						if (rx_bit_ff == `SCR_LAST_BIT)
							rx_st_ff <= RX_IDLE;
					end
				end
				default: rx_st_ff <= RX_IDLE;
			endcase
		end
	end

	// receive data register, loaded even for a bad frame
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			rxd_ff <= 8'h00;
		else if (rx_par_chk && !(rx_ok && rxf_ff))
			rxd_ff <= rx_sh_ff[8:1];
	end

	// data line: frame bits out, low error signal, else released
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			io_out_ff  <= 1'b1;
			io_oe_n_ff <= 1'b1;
		end else if (tx_st_ff == TX_SEND) begin
			io_out_ff  <= tx_frame_ff[tx_bit_ff];
			io_oe_n_ff <= 1'b0;
		end else if (rx_st_ff == RX_SLOT && rx_bad_ff
			&& rx_bit_ff == `SCR_SLOT_BIT) begin
			io_out_ff  <= 1'b0;                              // RULE_25
			io_oe_n_ff <= 1'b0;
		end else begin
			io_out_ff  <= 1'b1;
			io_oe_n_ff <= 1'b1;                              // RULE_10
		end
	end

	// clock pin stays released until card mode or clock output is set
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			sck_oe_n_ff <= 1'b1;                             // RULE_21
		else
			sck_oe_n_ff <= !(card_on || ctrl_ff[`SCR_CTRL_CKEN]);
	end

	// register read port, data valid the cycle after the strobe
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rd_data_ff <= 8'h00;
		end else begin
			rd_data_ff <= 8'h00;
			if (rd_stb) begin
				if (addr == `SCR_ADDR_CTRL)
					rd_data_ff <= ctrl_ff;
				else if (addr == `SCR_ADDR_MODE)
					rd_data_ff <= mode_ff;
				else if (addr == `SCR_ADDR_CARD)
					rd_data_ff <= card_ff;
				else if (addr == `SCR_ADDR_STS)
					rd_data_ff <= {tde_ff, rxf_ff, orun_ff, perr_ff,
						ers_ff, tx_done_flag_ff, 2'b00};
				else if (addr == `SCR_ADDR_TXD)
					rd_data_ff <= txd_ff;
				else if (addr == `SCR_ADDR_RXD)
					rd_data_ff <= rxd_ff;
				else if (addr == `SCR_ADDR_DIV)
					rd_data_ff <= div_ff;
			end
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_per_sets: // RULE_05
		assert property (rx_par_bad ##1 rx_irq_enable |=> error_irq_ff)
		else $error("parity fault did not raise error request");
	a_bad_no_full: // RULE_07
		assert property (rx_par_bad |=> perr_ff && !$rose(rxf_ff))
		else $error("bad parity frame set receive-full");
	a_good_full: // RULE_08
		assert property (rx_par_ok && !rxf_ff && !perr_ff
			|=> rxf_ff && !perr_ff)
		else $error("good frame did not set receive-full");
	a_dma_rx_clr: // RULE_09
		assert property (dma_rxd && rxf_ff && !rx_par_ok |=> !rxf_ff)
		else $error("dma read did not clear receive-full");
	a_good_release: // RULE_10
		assert property (rx_st_ff == RX_SLOT && !rx_bad_ff
			&& tx_st_ff == TX_IDLE |=> io_oe_n_ff)
		else $error("line driven after a good frame");
	a_ers_no_done: // RULE_13
		assert property (tx_err_seen |=> ers_ff && !tx_done_flag_ff)
		else $error("error signal not flagged or done set");
	a_resend: // RULE_23
		assert property (tx_end_evt && tx_err_ff
			|=> tx_st_ff == TX_SEND && tx_bit_ff == 4'h0 && !tx_done_flag_ff
			##1 !io_oe_n_ff && !io_out_ff)
		else $error("character not resent after error signal");
	a_done_sets: // RULE_14
		assert property (tx_good_end |=> tx_done_flag_ff && tde_ff
			##1 tx_empty_irq_ff == tx_irq_enable)
		else $error("transmit-done not set after clean frame");
	a_dma_tx_clr: // RULE_15
		assert property (dma_txd && !tx_good_end |=> !tde_ff && !tx_done_flag_ff)
		else $error("dma write did not clear transmit-empty");
endmodule : scr_top

// file: sim/scr_card.sv
// card model on the serial data line, clocked by the card clock pin
`timescale 1ns/1ps
module scr_card (
	// card clock and data line
	input  wire logic sck,
	input  wire logic line,
	// pull of the data line to ground
	output logic      drv_low
);
	logic       odd = 1'b0;
	int         nack_cnt = 0;
	bit         sending = 1'b0;
	logic [7:0] rx_q[$];

	// take a frame, refuse it on bad parity or when told to
	task automatic rx_frame;
		logic [9:0] f;
		logic       bad;
		for (int i = 0; i < 10; i++) begin
			repeat (186) @(posedge sck);
			f[i] = line;
			repeat (186) @(posedge sck);
		end
		rx_q.push_back(f[8:1]);
		bad = (f[9] !== (^f[8:1] ^ odd)) || (nack_cnt > 0);
		if (bad) begin
			if (nack_cnt > 0)
				nack_cnt--;
			drv_low = 1'b1;
			repeat (372) @(posedge sck);
			drv_low = 1'b0;
		end
	endtask : rx_frame

	// send one frame, then look for an error signal in the slot
	task automatic send_byte(input logic [7:0] d, input logic bad,
		output logic nak);
		logic [9:0] f;
		f = {^d ^ odd ^ bad, d, 1'b0};
		sending = 1'b1;
		for (int i = 0; i < 10; i++) begin
			@(posedge sck);
			drv_low = ~f[i];
			repeat (371) @(posedge sck);
		end
		@(posedge sck);
		drv_low = 1'b0;
		repeat (185) @(posedge sck);
		nak = ~line;
		repeat (562) @(posedge sck);
		sending = 1'b0;
	endtask : send_byte

	// watch for start bits sent by the channel
	initial begin
		drv_low = 1'b0;
		forever begin
			@(negedge line);
			if (!sending)
				rx_frame();
		end
	end
endmodule : scr_card

// file: sim/testbench.sv
// self-checking bench of the smart card serial channel
`timescale 1ns/1ps
`include "scr_map.svh"
module testbench;
	logic       clk_sys;
	logic       rst;
	logic [2:0] addr;
	logic [7:0] wr_data;
	logic       wr_stb;
	logic       rd_stb;
	logic       dma_access;
	logic [7:0] rd_data_ff;
	logic       error_irq_ff;
	logic       rx_full_irq_ff;
	logic       tx_empty_irq_ff;
	logic       io_out_ff;
	logic       io_oe_n_ff;
	logic       sck_out;
	logic       sck_oe_n_ff;
	logic       drv_low;
	logic       io_line;
	logic       sck_pin;
	logic       nak;
	logic       clk_chk;
	logic [7:0] d;
	logic [7:0] b;
	int         error_cnt = 0;
	int         tests_run = 0;
	int         hi_len = 0;
	int         oe_cnt = 0;
	int         oe_len = 0;

	// wired line with pull-up; clock pin pulled low when released
	assign io_line = ~drv_low & (io_oe_n_ff | io_out_ff);
	assign sck_pin = ~sck_oe_n_ff & sck_out;

	scr_top u_dut (.clk_sys(clk_sys), .rst(rst), .addr(addr),
		.wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
		.dma_access(dma_access), .rd_data_ff(rd_data_ff),
		.error_irq_ff(error_irq_ff), .rx_full_irq_ff(rx_full_irq_ff),
		.tx_empty_irq_ff(tx_empty_irq_ff), .io_in(io_line),
		.io_out_ff(io_out_ff), .io_oe_n_ff(io_oe_n_ff),
		.sck_out(sck_out), .sck_oe_n_ff(sck_oe_n_ff));
	scr_card u_card (.sck(sck_pin), .line(io_line), .drv_low(drv_low));

	// system clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic fail(input string m);
		error_cnt++;
		$display("MISMATCH t=%0t %s", $time, m);
	endtask : fail
	task automatic chk8(input logic [7:0] g, input logic [7:0] e,
		input string m);
		tests_run++;
		if (g !== e)
			fail($sformatf("%s got %h exp %h", m, g, e));
	endtask : chk8
	task automatic chk1(input logic g, input logic e, input string m);
		tests_run++;
		if (g !== e)
			fail(m);
	endtask : chk1
	task automatic chk_n(input int g, input int lo, input int hi,
		input string m);
		tests_run++;
		if (g < lo || g > hi)
			fail($sformatf("%s got %0d", m, g));
	endtask : chk_n
	task automatic tx_done_flag(input string n);
		$display("test %s finished", n);
	endtask : tx_done_flag

	// register port: one-cycle strobes, read data the cycle after
	task automatic wr(input logic [2:0] a, input logic [7:0] v,
		input logic dm);
		@(posedge clk_sys);
		addr <= a;
		wr_data <= v;
		wr_stb <= 1'b1;
		dma_access <= dm;
		@(posedge clk_sys);
		wr_stb <= 1'b0;
		dma_access <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic dm,
		output logic [7:0] q);
		@(posedge clk_sys);
		addr <= a;
		rd_stb <= 1'b1;
		dma_access <= dm;
		@(posedge clk_sys);
		rd_stb <= 1'b0;
		dma_access <= 1'b0;
		#1 q = rd_data_ff;
	endtask : rd
	task automatic rchk(input logic [2:0] a, input logic dm,
		input logic [7:0] e, input string m);
		rd(a, dm, d);
		chk8(d, e, m);
	endtask : rchk
	task automatic wait_sts(input int k);
		for (int n = 0; n < 15000; n++) begin
			rd(`SCR_ADDR_STS, 1'b0, d);
			if (d[k] === 1'b1)
				return;
		end
		fail("status bit never set");
	endtask : wait_sts
	task automatic hold(input logic lvl);
		repeat (20) begin
			@(negedge clk_sys);
			chk1(sck_out, lvl, "clock not held");
		end
	endtask : hold

	// length of clock high halves and of data line drive
	always @(negedge clk_sys) begin
		if (sck_out)
			hi_len <= hi_len + 1;
		else if (hi_len != 0) begin
			if (clk_chk)
				chk_n(hi_len, 4, 4, "clock high half");
			hi_len <= 0;
		end
		if (!io_oe_n_ff)
			oe_cnt <= oe_cnt + 1;
		else if (oe_cnt != 0) begin
			oe_len <= oe_cnt;
			oe_cnt <= 0;
		end
	end

	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done

	// watchdog
	initial begin
		repeat (90000) @(posedge clk_sys);
		fail("watchdog expired");
		test_done();
	end

	// main sequence
	initial begin
		rst = 1'b1;
		addr = 3'h0;
		wr_data = 8'h00;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		dma_access = 1'b0;
		clk_chk = 1'b0;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		rchk(`SCR_ADDR_CTRL, 0, 8'h00, "ctrl reset");
		rchk(`SCR_ADDR_MODE, 0, 8'h00, "mode reset");
		rchk(`SCR_ADDR_CARD, 0, 8'h00, "card reset");
		rchk(`SCR_ADDR_STS, 0, 8'h84, "status reset");
		rchk(`SCR_ADDR_DIV, 0, 8'h01, "div reset");
		rchk(3'h7, 0, 8'h00, "unmapped read");
		chk1(sck_oe_n_ff, 1'b1, "clock pin driven");
		chk1(io_oe_n_ff, 1'b1, "data pin driven");
		tx_done_flag("reset");
		wr(`SCR_ADDR_DIV, 8'h04, 0);
		wr(`SCR_ADDR_CTRL, 8'h00, 0);
		wr(`SCR_ADDR_CARD, 8'h01, 0);
		clk_chk = 1'b1;
		wr(`SCR_ADDR_CTRL, 8'h01, 0);
		repeat (40) @(posedge clk_sys);
		wr(`SCR_ADDR_CTRL, 8'h00, 0);
		repeat (10) @(posedge clk_sys);
		hold(1'b0);
		wr(`SCR_ADDR_CTRL, 8'h03, 0);
		repeat (40) @(posedge clk_sys);
		clk_chk = 1'b0;
		wr(`SCR_ADDR_CTRL, 8'h02, 0);
		repeat (10) @(posedge clk_sys);
		hold(1'b1);
		wr(`SCR_ADDR_MODE, 8'h00, 0);
		wr(`SCR_ADDR_CARD, 8'h00, 0);
		wr(`SCR_ADDR_CTRL, 8'h02, 0);
		wr(`SCR_ADDR_DIV, 8'h01, 0);
		wr(`SCR_ADDR_CARD, 8'h01, 0);
		wr(`SCR_ADDR_CTRL, 8'h03, 0);
		tx_done_flag("clock");
		// transmit, clean and with one refusal by the card
		wr(`SCR_ADDR_CTRL, 8'hE3, 0);
		wr(`SCR_ADDR_TXD, 8'h5A, 1);
		rchk(`SCR_ADDR_STS, 0, 8'h00, "dma write flags");
		chk1(tx_empty_irq_ff, 1'b0, "tx irq early");
		wait_sts(`SCR_STS_TX_DONE_FLAG);
		rchk(`SCR_ADDR_STS, 0, 8'h84, "sent status");
		chk1(tx_empty_irq_ff, 1'b1, "tx irq");
		chk8(u_card.rx_q.pop_front(), 8'h5A, "card data");
		chk_n(oe_len, 7438, 7442, "frame drive");
		u_card.nack_cnt = 1;
		wr(`SCR_ADDR_TXD, 8'hC3, 1);
		wait_sts(`SCR_STS_ERS);
		rchk(`SCR_ADDR_STS, 0, 8'h08, "refused status");
		chk1(error_irq_ff, 1'b1, "error irq");
		wr(`SCR_ADDR_STS, 8'hF7, 0);
		wait_sts(`SCR_STS_TX_DONE_FLAG);
		rchk(`SCR_ADDR_STS, 0, 8'h84, "resent status");
		chk1(error_irq_ff, 1'b0, "error irq stuck");
		chk8(u_card.rx_q.pop_front(), 8'hC3, "first copy");
		chk8(u_card.rx_q.pop_front(), 8'hC3, "second copy");
		tx_done_flag("transmit");
		// receive in even and odd parity, then a bad parity
		wr(`SCR_ADDR_CTRL, 8'h53, 0);
		for (int p = 0; p < 2; p++) begin
			wr(`SCR_ADDR_MODE, p ? 8'h10 : 8'h00, 0);
			u_card.odd = p[0];
			b = 8'h3C + 8'(p);
			u_card.send_byte(b, 1'b0, nak);
			chk1(nak, 1'b0, "slot driven");
			rchk(`SCR_ADDR_STS, 0, 8'hC4, "rx status");
			chk1(rx_full_irq_ff, 1'b1, "rx irq");
			rchk(`SCR_ADDR_RXD, 0, b, "cpu read");
			rchk(`SCR_ADDR_RXD, 1, b, "dma read");
			rchk(`SCR_ADDR_STS, 0, 8'h84, "full kept");
		end
		// two good frames without a read: the second one overruns
		u_card.send_byte(8'h11, 1'b0, nak);
		u_card.send_byte(8'h22, 1'b0, nak);
		rchk(`SCR_ADDR_STS, 0, 8'hE4, "overrun status");
		chk1(error_irq_ff, 1'b1, "overrun irq");
		rchk(`SCR_ADDR_RXD, 0, 8'h11, "first byte kept");
		wr(`SCR_ADDR_STS, 8'h9F, 0);
		rchk(`SCR_ADDR_STS, 0, 8'h84, "overrun cleared");
		u_card.send_byte(8'h96, 1'b1, nak);
		chk1(nak, 1'b1, "no error signal");
		rchk(`SCR_ADDR_STS, 0, 8'h94, "fault status");
		chk1(error_irq_ff, 1'b1, "error irq");
		chk1(rx_full_irq_ff, 1'b0, "rx irq on fault");
		rchk(`SCR_ADDR_RXD, 0, 8'h96, "faulty data");
		wr(`SCR_ADDR_STS, 8'hEF, 0);
		rchk(`SCR_ADDR_STS, 0, 8'h84, "fault kept");
		tx_done_flag("receive");
		test_done();
	end
endmodule : testbench
